// File: rtl/ahp_defines.vh
// Constants, timing figures and address map of the asynchronous host access port.
`ifndef AHP_DEFINES_VH
`define AHP_DEFINES_VH

`define AHP_ADDR_W 20
`define AHP_DATA_W 32
`define AHP_REGION_HI 19
`define AHP_REGION_LO 16
`define AHP_REGION_IOP 4'h0
`define AHP_REGION_MEM 4'h1
`define AHP_MEM_AW 8
`define AHP_IOP_AW 3
`define AHP_IOP_N 8
`define AHP_CNT_W 4

// Clock period and the extra delay term, both in ns.
`define AHP_CLK_NS 4
`define AHP_DT_NS 0
// Least low widths of the wait line in ns (read and write).
`define AHP_RD_WAIT_NS (45 + (21 * `AHP_DT_NS) / 16)
`define AHP_WR_WAIT_NS (15 + (7 * `AHP_DT_NS) / 16)
// Least widths round up to whole cycles.
`define AHP_RD_WAIT_CYC ((`AHP_RD_WAIT_NS + `AHP_CLK_NS - 1) / `AHP_CLK_NS)
`define AHP_WR_WAIT_CYC ((`AHP_WR_WAIT_NS + `AHP_CLK_NS - 1) / `AHP_CLK_NS)

`endif

// File: rtl/ahp_mem.v
// Internal word memory reached through the host port, with registered read data.
`timescale 1ns/1ns
`default_nettype none
`include "ahp_defines.vh"
module ahp_mem (
   input wire clk,
   input wire wr_en,
   input wire [`AHP_MEM_AW-1:0] addr,
   input wire [`AHP_DATA_W-1:0] wdata,
   output reg [`AHP_DATA_W-1:0] rdata
);
   reg [`AHP_DATA_W-1:0] store [0:(1 << `AHP_MEM_AW)-1];

   // A read in the cycle of a write returns the old word; no reset so it maps onto block RAM.
   always @(posedge clk) begin
      if (wr_en) begin
         store[addr] <= wdata;
      end
      rdata <= store[addr];
   end
endmodule
`default_nettype wire

// File: rtl/ahp_host_port.v
// Slave side of the asynchronous host access port: grant, wait line, reads and writes.
`timescale 1ns/1ns
`default_nettype none
`include "ahp_defines.vh"
module ahp_host_port (
   input wire clk,
   input wire nrst,
   input wire host_sel_n,
   input wire host_bus_request_n,
   output reg host_bus_grant_n,
   input wire host_rd_n,
   input wire host_wr_n,
   input wire [`AHP_ADDR_W-1:0] host_addr,
   input wire [`AHP_DATA_W-1:0] host_data_in,
   output reg [`AHP_DATA_W-1:0] host_data_out,
   output reg host_data_oe,
   input wire wait_active_drive,
   output reg host_wait_ack_out,
   output reg host_wait_ack_oe,
   output reg [`AHP_DATA_W-1:0] iop_ctrl
);
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_GRANT = 7'h02;
   localparam [6:0] ST_RD_WAIT = 7'h04;
   localparam [6:0] ST_WR_WAIT = 7'h08;
   localparam [6:0] ST_RD_END = 7'h10;
   localparam [6:0] ST_WR_END = 7'h20;
   localparam [6:0] ST_TURN = 7'h40;
   // Counts are worked out as integers and cut to the counter width on purpose.
   localparam integer RD_CYC = `AHP_RD_WAIT_CYC;
   localparam integer WR_CYC = `AHP_WR_WAIT_CYC;
   localparam [`AHP_CNT_W-1:0] RD_CNT = RD_CYC[`AHP_CNT_W-1:0];
   localparam [`AHP_CNT_W-1:0] WR_CNT = WR_CYC[`AHP_CNT_W-1:0];
   localparam [`AHP_CNT_W-1:0] CNT_ONE = 4'h1;

   reg rst_meta;
   reg rst_sync;
   reg [6:0] state;
   reg [6:0] next_state;
   reg [`AHP_CNT_W-1:0] wait_cnt;
   reg [`AHP_ADDR_W-1:0] cap_addr;
   reg [`AHP_DATA_W-1:0] cap_data;
   reg [`AHP_DATA_W-1:0] iop_regs [0:`AHP_IOP_N-1];
   reg wait_low;
   reg rd_data_ok;
   wire [`AHP_DATA_W-1:0] mem_rdata;
   wire [3:0] region;
   wire sel_mem;
   wire sel_iop;
   wire strobe_ok;
   wire commit;
   wire mem_wr;
   integer i;

   // Reset is asserted at once and released through two flops.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign region = cap_addr[`AHP_REGION_HI:`AHP_REGION_LO];
   assign sel_mem = (region == `AHP_REGION_MEM);
   assign sel_iop = (region == `AHP_REGION_IOP);
   assign strobe_ok = !host_sel_n && !host_bus_request_n && !host_bus_grant_n;
   assign commit = (state == ST_WR_END) && host_wr_n;
   assign mem_wr = commit && sel_mem;

   ahp_mem u_mem (
      .clk(clk),
      .wr_en(mem_wr),
      .addr(cap_addr[`AHP_MEM_AW-1:0]),
      .wdata(cap_data),
      .rdata(mem_rdata)
   );

   // Next state of the access sequencer.
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (!host_bus_request_n && !host_sel_n) begin
               next_state = ST_GRANT;
            end
         end
         ST_GRANT: begin
            if (host_bus_request_n) begin
               next_state = ST_IDLE;
            end else if (strobe_ok && !host_rd_n) begin
               next_state = ST_RD_WAIT;
            end else if (strobe_ok && !host_wr_n) begin
               next_state = ST_WR_WAIT;
            end
         end
         ST_RD_WAIT: begin
            if (wait_cnt == CNT_ONE) begin
               next_state = ST_RD_END;
            end
         end
         ST_WR_WAIT: begin
            if (wait_cnt == CNT_ONE) begin
               next_state = ST_WR_END;
            end
         end
         ST_RD_END: begin
            if (host_rd_n) begin
               next_state = ST_TURN;
            end
         end
         ST_WR_END: begin
            if (host_wr_n) begin
               next_state = ST_GRANT;
            end
         end
         ST_TURN: begin
            next_state = ST_GRANT;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer, wait counter and capture of the host's address and data.
   always @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= ST_IDLE;
         wait_cnt <= {`AHP_CNT_W{1'b0}};
         cap_addr <= {`AHP_ADDR_W{1'b0}};
         cap_data <= {`AHP_DATA_W{1'b0}};
         host_bus_grant_n <= 1'b1;
      end else begin
         state <= next_state;
         host_bus_grant_n <= host_bus_request_n;
         if (state == ST_GRANT) begin
            cap_addr <= host_addr;
            wait_cnt <= host_rd_n ? WR_CNT : RD_CNT;
         end else if (wait_cnt != {`AHP_CNT_W{1'b0}}) begin
            wait_cnt <= wait_cnt - CNT_ONE;
         end
         // Track address and data while the write strobe is low so the
         // values seen just before the rising edge are the ones committed.
         if (!host_wr_n && (state == ST_WR_WAIT || state == ST_WR_END)) begin
            cap_addr <= host_addr;
            cap_data <= host_data_in;
         end
      end
   end

   always @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         for (i = 0; i < `AHP_IOP_N; i = i + 1) begin
            iop_regs[i] <= {`AHP_DATA_W{1'b0}};
         end
         iop_ctrl <= {`AHP_DATA_W{1'b0}};
      end else begin
         if (commit && sel_iop) begin
            iop_regs[cap_addr[`AHP_IOP_AW-1:0]] <= cap_data;
         end
         iop_ctrl <= iop_regs[0];
      end
   end

   // Wait line level: low from the strobe until the counted width ends.
   always @* begin
      wait_low = (state == ST_GRANT && strobe_ok && !(host_rd_n && host_wr_n))
         || ((state == ST_RD_WAIT || state == ST_WR_WAIT) && wait_cnt != CNT_ONE);
   end

   always @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         host_wait_ack_out <= 1'b1;
         host_wait_ack_oe <= 1'b0;
      end else begin
         host_wait_ack_out <= !wait_low;
         host_wait_ack_oe <= wait_low || (wait_active_drive && !host_sel_n
            && !host_bus_request_n);
      end
   end

   // Read data path; data are loaded while the wait line is still low.
   always @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         host_data_out <= {`AHP_DATA_W{1'b0}};
         host_data_oe <= 1'b0;
         rd_data_ok <= 1'b0;
      end else begin
         rd_data_ok <= (state == ST_RD_WAIT);
         if (state == ST_RD_WAIT && rd_data_ok) begin
            host_data_out <= sel_mem ? mem_rdata :
               (sel_iop ? iop_regs[cap_addr[`AHP_IOP_AW-1:0]] : {`AHP_DATA_W{1'b0}});
            host_data_oe <= 1'b1;
         end else if (state == ST_TURN) begin
            // bus let go after strobe rise
            host_data_oe <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/ahp_port_chk_asserts.sv
// Timing checker of the host access port, bound to the port module.
`timescale 1ns/1ns
`default_nettype none
`include "ahp_defines.vh"
module ahp_port_chk (
   input wire clk,
   input wire nrst,
   input wire host_sel_n,
   input wire host_bus_request_n,
   input wire host_bus_grant_n,
   input wire host_rd_n,
   input wire host_wr_n,
   input wire [`AHP_DATA_W-1:0] host_data_out,
   input wire host_data_oe,
   input wire wait_active_drive,
   input wire host_wait_ack_out,
   input wire host_wait_ack_oe
);
   // The wait line is low only while the port drives it low.
   wire wl = host_wait_ack_oe && !host_wait_ack_out;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_grant_follows:
   assert property (!host_bus_request_n |=> !host_bus_grant_n) else $error("grant late");
   a_wait_starts:
   assert property (($fell(host_rd_n) || $fell(host_wr_n)) && !host_sel_n && !host_bus_grant_n
      |=> wl) else $error("wait not started");
   a_read_wait:
   assert property ($rose(wl) && !host_rd_n |-> wl[*8] ##1 wl[*4] ##1 !wl)
      else $error("read wait width");
   a_write_wait:
   assert property ($rose(wl) && host_rd_n |-> wl[*4] ##1 !wl) else $error("write wait width");
   a_data_valid:
   assert property ($rose(host_wait_ack_out) && !host_rd_n
      |-> host_data_oe && $past(host_data_oe) && $stable(host_data_out))
      else $error("read data not ready");
   a_data_let_go:
   assert property ($rose(host_rd_n) && host_data_oe |=> host_data_oe ##[1:2] !host_data_oe)
      else $error("data bus release");
   a_refused:
   assert property ($fell(host_rd_n) && host_bus_grant_n |=> (!wl)[*3])
      else $error("strobe without grant");
   a_open_drain:
   assert property (!wait_active_drive |-> !(host_wait_ack_oe && host_wait_ack_out))
      else $error("open drain drove high");
   a_active_drive:
   assert property ((wait_active_drive && !host_sel_n && !host_bus_request_n)[*2]
      |-> host_wait_ack_oe) else $error("active drive off");
endmodule
bind ahp_host_port ahp_port_chk u_chk (.clk, .nrst, .host_sel_n, .host_bus_request_n,
   .host_bus_grant_n, .host_rd_n, .host_wr_n, .host_data_out, .host_data_oe,
   .wait_active_drive, .host_wait_ack_out, .host_wait_ack_oe);
`default_nettype wire

// File: verification/ahp_host.sv
// Host processor model driving the asynchronous access port.
`timescale 1ns/1ns
`default_nettype none
`include "ahp_defines.vh"
module ahp_host (
   input wire clk,
   input wire grant_n,
   input wire wait_line,
   input wire [`AHP_DATA_W-1:0] rdata,
   output reg sel_n = 1'b1,
   output reg req_n = 1'b1,
   output reg rd_n = 1'b1,
   output reg wr_n = 1'b1,
   output reg [`AHP_ADDR_W-1:0] addr = 20'h00000,
   output reg [`AHP_DATA_W-1:0] wdata = 32'h00000000,
   output reg hung = 1'b0
);
   integer n;
   task request(input v);
   begin
      @(negedge clk);
      sel_n = v;
      req_n = v;
      for (n = 0; n < 8 && grant_n !== v; n = n + 1) @(posedge clk);
      hung = hung | (grant_n !== v);
      // Region field set to memory once granted, so the first address is never
      // multiprocessor space.
      if (!v) begin
         @(negedge clk);
         addr[`AHP_REGION_HI:`AHP_REGION_LO] = `AHP_REGION_MEM;
      end
   end
   endtask
   task xfer(input wr, input [`AHP_ADDR_W-1:0] a, input [`AHP_DATA_W-1:0] d,
      output [`AHP_DATA_W-1:0] q);
   begin
      @(negedge clk);
      hung = hung | (grant_n !== 1'b0);
      addr = a;
      wdata = d;
      rd_n = wr;
      wr_n = !wr;
      for (n = 0; n < 20 && wait_line !== 1'b0; n = n + 1) @(posedge clk);
      // A wait line that never falls is a refused access and counts as a hang.
      hung = hung | (wait_line !== 1'b0);
      for (n = 0; n < 40 && wait_line !== 1'b1; n = n + 1) @(posedge clk);
      hung = hung | (wait_line !== 1'b1);
      q = rdata;
      @(negedge clk);
      rd_n = 1'b1;
      wr_n = 1'b1;
      // Held past the rising strobe, then let go so stale values cannot pass.
      repeat (2) @(negedge clk);
      addr = ~a;
      wdata = ~d;
   end
   endtask
endmodule
`default_nettype wire

// File: verification/test_ahp_host_port.sv
// Self-checking bench of the host access port.
`timescale 1ns/1ns
`default_nettype none
`include "ahp_defines.vh"
module test_ahp_host_port;
   reg clk = 1'b0;
   reg nrst = 1'b0;
   reg wait_active_drive = 1'b0;
   wire host_sel_n, host_bus_request_n, host_bus_grant_n, host_rd_n, host_wr_n;
   wire host_data_oe, host_wait_ack_out, host_wait_ack_oe;
   wire [`AHP_ADDR_W-1:0] host_addr;
   wire [`AHP_DATA_W-1:0] host_data_in, host_data_out, iop_ctrl;
   // Wait line with its pull-up when undriven.
   wire wait_line = host_wait_ack_oe ? host_wait_ack_out : 1'b1;
   // A released data bus shows the inverse of the last word, so an undriven read fails.
   wire [`AHP_DATA_W-1:0] data_bus = host_data_oe ? host_data_out : ~host_data_out;
   reg [`AHP_DATA_W-1:0] q;
   integer failures = 0;
   integer n_checks = 0;
   ahp_host_port dut (.clk, .nrst, .host_sel_n, .host_bus_request_n, .host_bus_grant_n,
      .host_rd_n, .host_wr_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
      .wait_active_drive, .host_wait_ack_out, .host_wait_ack_oe, .iop_ctrl);
   ahp_host host (.clk, .grant_n(host_bus_grant_n), .wait_line, .rdata(data_bus),
      .sel_n(host_sel_n), .req_n(host_bus_request_n), .rd_n(host_rd_n), .wr_n(host_wr_n),
      .addr(host_addr), .wdata(host_data_in), .hung());
   // Clock of 4 ns.
   initial begin
      forever #2 clk = ~clk;
   end
   task check(input [`AHP_DATA_W-1:0] seen, input [`AHP_DATA_W-1:0] want);
   begin
      n_checks = n_checks + 1;
      if (seen !== want) begin
         failures = failures + 1;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   end
   endtask
   task wrap_up;
   begin
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   end
   endtask
   // A hung access counts as a mismatch and ends the run.
   task hang_chk;
   begin
      if (host.hung) begin
         failures = failures + 1;
         wrap_up;
      end
   end
   endtask
   task acc(input wr, input [`AHP_ADDR_W-1:0] a, input [`AHP_DATA_W-1:0] d);
   begin
      host.xfer(wr, a, d, q);
      hang_chk;
   end
   endtask
   task t_iop;
   begin
      acc(1'b1, 20'h00000, 32'h5a5a0001);
      repeat (3) @(negedge clk);
      check(iop_ctrl, 32'h5a5a0001);
      acc(1'b0, 20'h00000, 32'h00000000);
      check(q, 32'h5a5a0001);
   end
   endtask
   // Back-to-back writes, one into the multiprocessor space that must be dropped.
   task t_mem;
   begin
      acc(1'b1, 20'h10003, 32'ha1a10003);
      acc(1'b1, 20'h100ff, 32'hb2b200ff);
      acc(1'b1, 20'h20003, 32'hdead0003);
      acc(1'b0, 20'h10003, 32'h00000000);
      check(q, 32'ha1a10003);
      acc(1'b0, 20'h100ff, 32'h00000000);
      check(q, 32'hb2b200ff);
      acc(1'b0, 20'h20003, 32'h00000000);
      check(q, 32'h00000000);
   end
   endtask
   // Strobe with the grant withdrawn is ignored.
   task t_refuse;
   begin
      host.request(1'b1);
      @(negedge clk);
      host.rd_n = 1'b0;
      repeat (4) @(posedge clk);
      check({31'h0, wait_line}, 32'h1);
      @(negedge clk);
      host.rd_n = 1'b1;
      host.request(1'b0);
      hang_chk;
   end
   endtask
   // Wait line styles: released in open drain, driven in active mode.
   task t_active;
   begin
      @(negedge clk);
      check({31'h0, host_wait_ack_oe}, 32'h0);
      wait_active_drive = 1'b1;
      repeat (3) @(negedge clk);
      check({31'h0, host_wait_ack_oe}, 32'h1);
      acc(1'b0, 20'h100ff, 32'h00000000);
      check(q, 32'hb2b200ff);
   end
   endtask
   // Main sequence.
   initial begin
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      host.request(1'b0);
      hang_chk;
      t_iop;
      t_mem;
      t_refuse;
      t_active;
      wrap_up;
   end
endmodule
`default_nettype wire
